/* File: src/cbus_port_pkg.sv */
// constants for the management host port
package cbus_port_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 64;
  // event cause / mask register addresses inside the 64-entry file
  localparam logic [5:0] CAUSE_ADDR = 6'h02;
  localparam logic [5:0] MASK_ADDR = 6'h03;
  // field positions in the cause register
  localparam int unsigned PARITY_FAULT_BIT = 0;
  localparam int unsigned NUM_EVENTS = 8;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // cycles from select seen low (synchronised) to register access
  localparam int unsigned SYNC_STAGES = 2;
endpackage

/* File: src/cbus_host_port.sv */
// management host port with register file, parity check and event logic
//
// Operation
// - sixty-four registers, eight bits each, reachable through the port
// - six-bit address, top line most significant
// - select low opens one access; select high ignores other inputs
// - direction high reads, low writes
// - acknowledge pulled low marks completion of each access
// - read data driven and stable while acknowledge low
// - acknowledge stays low while select stays low
// - interrupt pulled low while any unmasked cause bit is set
// - each cause individually masked; software reads cause register
// - parity line carries odd parity over the eight data bits
// - read parity driven and held while acknowledge low
// - bad write parity blocks the write and sets the fault cause
`timescale 1ns/1ps
module cbus_host_port
  import cbus_port_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // host port
  input wire logic selectN,
  input wire logic readNotWrite,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DATA_W-1:0] regBusDataIn,
  output logic [DATA_W-1:0] regBusDataOut,
  output logic regBusDataOe,
  input wire logic busParityBitIn,
  output logic busParityBitOut,
  output logic busParityBitOe,
  output logic ackOutN,
  output logic ackOe,
  output logic intOutN,
  output logic intOe,
  // device event sources, one-cycle pulses
  input wire logic [NUM_EVENTS-1:0] eventPulse
);

  // ****************************************
  // checks and helpers
  // ****************************************
  // refused at elaboration: the register file decode is built for six lines
  if (AW != ADDR_W) begin : g_bad_width
    $error("address width must be six");
  end

  // odd parity: the parity bit makes the nine-bit total odd
  function automatic logic oddPar(input logic [DATA_W-1:0] d);
    oddPar = ~(^d);
  endfunction

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    ACCESS = 3'b010,
    HOLD = 3'b100
  } port_e;

  // ****************************************
  // select synchroniser
  // ****************************************
  logic selSync1_q;
  logic selSync2_q;
  // first stage only feeds second; select pin is asynchronous
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      selSync1_q <= 1'b0;
      selSync2_q <= 1'b0;
    end else begin
      selSync1_q <= ~selectN;
      selSync2_q <= selSync1_q;
    end
  end

  // ****************************************
  // access sequencer
  // ****************************************
  port_e state_q;
  logic [DATA_W-1:0] rdData_q;
  logic reading_q;
  logic [DATA_W-1:0] regFile_q [NUM_REGS];
  logic [DATA_W-1:0] cause_q;
  logic [DATA_W-1:0] mask_q;
  logic doAccess;
  logic doWrite;
  logic parityOk;
  logic [DATA_W-1:0] readMux;

  // inputs are sampled two cycles after select fell, so they have settled
  assign doAccess = (state_q == IDLE) && selSync2_q;
  assign parityOk = (busParityBitIn == oddPar(regBusDataIn));
  assign doWrite = doAccess && !readNotWrite && parityOk;

  always_comb begin
    if (reg_addr == CAUSE_ADDR) begin
      readMux = cause_q;
    end else if (reg_addr == MASK_ADDR) begin
      readMux = mask_q;
    end else begin
      readMux = regFile_q[reg_addr];
    end
  end

  // one access per select assertion; wait for select to drop
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= IDLE;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (selSync2_q) begin
            state_q <= ACCESS;
          end
        end
        ACCESS: begin
          state_q <= HOLD;
        end
        HOLD: begin
          if (!selSync2_q) begin
            state_q <= IDLE;
          end
        end
        default: begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  // read data captured once so it is stable for the whole acknowledge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdData_q <= REG_RESET;
      reading_q <= 1'b0;
    end else if (doAccess) begin
      rdData_q <= readMux;
      reading_q <= readNotWrite;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  // plain storage; cause and mask live outside the array
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regFile_q[i] <= REG_RESET;
      end
    end else if (doWrite && reg_addr != CAUSE_ADDR && reg_addr != MASK_ADDR) begin
      regFile_q[reg_addr] <= regBusDataIn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mask_q <= MASK_RESET;
    end else if (doWrite && reg_addr == MASK_ADDR) begin
      mask_q <= regBusDataIn;
    end
  end

  // ****************************************
  // event cause logic
  // ****************************************
  logic [DATA_W-1:0] causeSet;
  logic [DATA_W-1:0] causeClr;
  always_comb begin
    causeSet = eventPulse;
    causeSet[PARITY_FAULT_BIT] = eventPulse[PARITY_FAULT_BIT]
      | (doAccess && !readNotWrite && !parityOk);
    // writing a one clears a cause bit; a parity-bad write clears nothing
    causeClr = (doWrite && reg_addr == CAUSE_ADDR) ? regBusDataIn : '0;
  end

  // set wins over clear so no event is lost
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cause_q <= REG_RESET;
    end else begin
      cause_q <= (cause_q & ~causeClr) | causeSet;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic ackActive;
  assign ackActive = (state_q == HOLD);
  assign ackOutN = 1'b0;
  assign ackOe = ackActive;
  assign regBusDataOut = rdData_q;
  assign regBusDataOe = ackActive && reading_q;
  assign busParityBitOut = oddPar(rdData_q);
  assign busParityBitOe = ackActive && reading_q;
  assign intOutN = 1'b0;
  assign intOe = |(cause_q & mask_q);

  // ****************************************
  // assertions
  // ****************************************
  a_ack_after_select: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(selSync2_q) && state_q == IDLE |=> ##1 ackOe)
    else $error("acknowledge late after select");
  a_ack_holds_select: assert property (@(posedge clk_sys) disable iff (!rstn)
    ackOe && selSync2_q |=> ackOe)
    else $error("acknowledge dropped while selected");
  a_release_on_deselect: assert property (@(posedge clk_sys) disable iff (!rstn)
    ackOe && !selSync2_q |=> !ackOe && !regBusDataOe && !busParityBitOe)
    else $error("lines not released after deselect");
  a_read_data_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
    regBusDataOe && $past(regBusDataOe) |-> $stable(regBusDataOut))
    else $error("read data changed under acknowledge");
  a_read_parity_odd: assert property (@(posedge clk_sys) disable iff (!rstn)
    busParityBitOe |-> ^{busParityBitOut, regBusDataOut})
    else $error("read parity not odd");
  a_bad_parity_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    doAccess && !readNotWrite && !parityOk |=> cause_q[PARITY_FAULT_BIT])
    else $error("parity fault not flagged");
  a_bad_parity_block: assert property (@(posedge clk_sys) disable iff (!rstn)
    doAccess && !readNotWrite && !parityOk && reg_addr == MASK_ADDR
      |=> $stable(mask_q))
    else $error("bad parity write changed register");
  a_one_access: assert property (@(posedge clk_sys) disable iff (!rstn)
    doAccess |=> !doAccess [*2])
    else $error("second access in one select");
  a_int_masked: assert property (@(posedge clk_sys) disable iff (!rstn)
    intOe == |(cause_q & mask_q))
    else $error("interrupt disagrees with mask");
  a_write_stores: assert property (@(posedge clk_sys) disable iff (!rstn)
    doWrite && reg_addr == MASK_ADDR |=> mask_q == $past(regBusDataIn))
    else $error("good write not stored");
endmodule

/* File: dv/host_model.sv */
// station management host model driving the port pins
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_sys,
  // pin levels
  input wire logic ackW,
  input wire logic [7:0] dataW,
  input wire logic parW,
  input wire logic dataOe,
  // host drive
  output logic selectN,
  output logic readNotWrite,
  output logic [5:0] reg_addr,
  output logic [7:0] dDrv,
  output logic pDrv,
  output logic drvEn
);
  // idle: deselected, bus not driven
  initial begin
    selectN = 1'b1;
    readNotWrite = 1'b1;
    reg_addr = 6'h00;
    dDrv = 8'h00;
    pDrv = 1'b0;
    drvEn = 1'b0;
  end
  // one access; ok drops if the acknowledge misbehaves
  task automatic access(input bit rd, input logic [5:0] a, input logic [7:0] d,
      input bit badp, input int hold, output logic [8:0] q, output logic ok);
    int n;
    ok = 1'b1;
    @(posedge clk_sys) #1;
    selectN = 1'b0;
    readNotWrite = rd;
    reg_addr = a;
    dDrv = d;
    pDrv = ~^d ^ badp;
    drvEn = !rd;
    n = 0;
    while (ackW !== 1'b0 && n < 10) begin
      @(posedge clk_sys) #1;
      n++;
    end
    q = {parW, dataW};
    if (n == 10) ok = 1'b0;
    // slow host: keep select low a while
    repeat (hold) begin
      @(posedge clk_sys) #1;
      if (ackW !== 1'b0 || {parW, dataW} !== q) ok = 1'b0;
    end
    selectN = 1'b1;
    drvEn = 1'b0;
    n = 0;
    while (ackW !== 1'b1 && n < 10) begin
      @(posedge clk_sys) #1;
      n++;
    end
    if (n == 10 || dataOe !== 1'b0) ok = 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

/* File: dv/tb_control_bus_host_port.sv */
// self-checking bench for the management host port
`timescale 1ns/1ps
module tb_control_bus_host_port;
  import cbus_port_pkg::*;
  logic clk_sys, rstn, selectN, readNotWrite, drvEn, pDrv;
  logic regBusDataOe, busParityBitOut, busParityBitOe, ackOutN, ackOe, intOutN, intOe;
  logic [NUM_EVENTS-1:0] eventPulse;
  logic [5:0] reg_addr;
  logic [7:0] dDrv, regBusDataOut, dataW;
  logic [7:0] model [64];
  logic ackW, intW, parW;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 147;
  // pin levels: open drain pulled up; a released bus shows the inverse
  assign ackW = ackOe ? ackOutN : 1'b1;
  assign intW = intOe ? intOutN : 1'b1;
  assign dataW = regBusDataOe ? regBusDataOut : (drvEn ? dDrv : ~dDrv);
  assign parW = busParityBitOe ? busParityBitOut : (drvEn ? pDrv : ~pDrv);
  cbus_host_port u_cbus_host_port (.clk_sys(clk_sys), .rstn(rstn), .selectN(selectN),
    .readNotWrite(readNotWrite), .reg_addr(reg_addr), .regBusDataIn(dataW),
    .regBusDataOut(regBusDataOut), .regBusDataOe(regBusDataOe), .busParityBitIn(parW),
    .busParityBitOut(busParityBitOut), .busParityBitOe(busParityBitOe), .ackOutN(ackOutN),
    .ackOe(ackOe), .intOutN(intOutN), .intOe(intOe), .eventPulse(eventPulse));
  host_model u_host_model (.clk_sys(clk_sys), .ackW(ackW), .dataW(dataW), .parW(parW),
    .dataOe(regBusDataOe), .selectN(selectN), .readNotWrite(readNotWrite),
    .reg_addr(reg_addr), .dDrv(dDrv), .pDrv(pDrv), .drvEn(drvEn));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [8:0] par9(input logic [7:0] d);
    return {~^d, d};
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input bit rd, input logic [5:0] a, input logic [7:0] d,
      input bit badp, output logic [8:0] q);
    logic ok;
    u_host_model.access(rd, a, d, badp, $unsigned($random(seed)) % 4, q, ok);
    chk({8'h00, ok}, 9'h001);
  endtask
  task automatic sweep;
    logic [8:0] q;
    for (int i = 0; i < 64; i++) begin
      xfer(1'b1, 6'(i), 8'h00, 1'b0, q);
      chk(q, par9(model[i]));
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog, far beyond the few thousand cycles needed
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    logic [8:0] q;
    logic [5:0] a;
    logic [7:0] d;
    rstn = 1'b0;
    eventPulse = '0;
    for (int i = 0; i < 64; i++) model[i] = REG_RESET;
    model[MASK_ADDR] = MASK_RESET;
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
    sweep();
    // random writes, both end addresses first; status registers kept out
    for (int i = 0; i < 40; i++) begin
      a = (i < 2) ? {6{i[0]}} : 6'($random(seed));
      if (a == CAUSE_ADDR || a == MASK_ADDR) a = a ^ 6'h08;
      d = 8'($random(seed));
      xfer(1'b0, a, d, 1'b0, q);
      model[a] = d;
    end
    sweep();
    // bad write parity: store blocked, fault cause set, masked until enabled
    xfer(1'b0, 6'h15, ~model[6'h15], 1'b1, q);
    xfer(1'b1, 6'h15, 8'h00, 1'b0, q);
    chk(q, par9(model[6'h15]));
    xfer(1'b1, CAUSE_ADDR, 8'h00, 1'b0, q);
    chk(q, par9(8'h01 << PARITY_FAULT_BIT));
    chk({8'h00, intW}, 9'h001);
    xfer(1'b0, MASK_ADDR, 8'h01 << PARITY_FAULT_BIT, 1'b0, q);
    chk({8'h00, intW}, 9'h000);
    xfer(1'b0, CAUSE_ADDR, 8'hff, 1'b0, q);
    // each event alone unmasked, its neighbour masked
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, MASK_ADDR, 8'h01 << k, 1'b0, q);
      chk({8'h00, intW}, 9'h001);
      @(posedge clk_sys) #1 eventPulse = 8'h03 << k | 8'h03 >> (8 - k);
      @(posedge clk_sys) #1 eventPulse = '0;
      repeat (2) @(posedge clk_sys);
      #1 chk({8'h00, intW}, 9'h000);
      xfer(1'b1, CAUSE_ADDR, 8'h00, 1'b0, q);
      chk(q, par9(8'h03 << k | 8'h03 >> (8 - k)));
      xfer(1'b0, CAUSE_ADDR, 8'hff, 1'b0, q);
    end
    // mid-run reset with an event pending: all storage back to reset values
    @(posedge clk_sys) #1 eventPulse = 8'h80;
    @(posedge clk_sys) #1 eventPulse = '0;
    chk({8'h00, intW}, 9'h000);
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'b1;
    chk({8'h00, intW}, 9'h001);
    for (int i = 0; i < 64; i++) model[i] = REG_RESET;
    model[MASK_ADDR] = MASK_RESET;
    sweep();
    tally_and_finish();
  end
endmodule
